// >>> hdl/low_speed_clock_select.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`include "low_speed_clock_select_consts.svh"

module low_speed_clock_select (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [3:0] factory_trim,
    input wire logic sleep_timeout,
    output low_speed_clock_select_pkg::reg_byte_t rdata,
    output logic slow_freq_select,
    output logic powerdown_bias_off,
    output logic [3:0] slow_trim,
    output logic [2:0] crystal_amp_gain,
    output logic [1:0] crystal_gain_mode,
    output logic crystal_low_power,
    output logic crystal_osc_enable,
    output logic internal_slow_osc_enable,
    output logic clk32_source_crystal,
    output logic [1:0] sleep_interval,
    output logic sleep_timer_clear,
    output low_speed_clock_select_pkg::crystal_power_t crystal_power_state
);
    import low_speed_clock_select_pkg::*;

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [2:0] crystal_enable_code;
    logic crystal_present_flag;
    logic crystal_flag_written;
    logic crystal_select;
    logic [1:0] slow_reserved;
    logic boot_pending;
    logic crystal_permitted;
    crystal_power_t next_power_state;
    localparam reg_byte_t TUNE_RST = `RESET_LOW_SPEED_OSC_TUNE;
    localparam reg_byte_t ENABLE_RST = `RESET_CRYSTAL_ENABLE_BUS;
    localparam reg_byte_t GAIN_RST = `RESET_CRYSTAL_GAIN_POWER_TUNE;
    localparam reg_byte_t CONFIG_RST = `RESET_CRYSTAL_CONFIG_LOCK;
    localparam reg_byte_t CONTROL_RST = `RESET_OSC_CONTROL_ZERO;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
        hit = (a == t);
    endfunction : hit

    function automatic logic write_to(input logic [7:0] t);
        write_to = ce && wr && hit(addr, t);
    endfunction : write_to

    // Crystal may only run with the present flag set, the enable code open
    // and the select bit set.
    assign crystal_permitted = crystal_present_flag && crystal_select &&
        (crystal_enable_code == `CRYSTAL_CODE_ENABLE);

    // ****************************************************************
    // Slow oscillator tune register
    // ****************************************************************
    // The trim is captured from the factory value on the first enabled
    // cycle after reset; bus writes cannot touch it.
    always_ff @(posedge clk) begin
        if (reset) begin
            slow_trim <= TUNE_RST[3:0];
            boot_pending <= 1'b1;
        end else if (ce && boot_pending) begin
            slow_trim <= factory_trim;
            boot_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            slow_freq_select <= TUNE_RST[`POS_SLOW_FREQ_SELECT];
            powerdown_bias_off <= TUNE_RST[`POS_POWERDOWN_BIAS_OFF];
            slow_reserved <= {TUNE_RST[7], TUNE_RST[4]};
        end else if (write_to(`ADDR_LOW_SPEED_OSC_TUNE)) begin
            slow_freq_select <= wdata[`POS_SLOW_FREQ_SELECT];
            powerdown_bias_off <= wdata[`POS_POWERDOWN_BIAS_OFF];
            slow_reserved <= {wdata[7], wdata[4]};
        end
    end

    // ****************************************************************
    // Crystal enable code and gain/power tune
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            crystal_enable_code <= ENABLE_RST[2:0];
        end else if (write_to(`ADDR_CRYSTAL_ENABLE_BUS)) begin
            crystal_enable_code <= wdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            crystal_amp_gain <= GAIN_RST[4:2];
            crystal_gain_mode <= GAIN_RST[1:0];
        end else if (write_to(`ADDR_CRYSTAL_GAIN_POWER_TUNE)) begin
            crystal_amp_gain <= wdata[4:2];
            crystal_gain_mode <= wdata[1:0];
        end
    end

    // ****************************************************************
    // Crystal configuration lock
    // ****************************************************************
    // Only the present flag is write-once; the low-power bit stays
    // writable so firmware can enter and leave it around sleep.
    always_ff @(posedge clk) begin
        if (reset) begin
            crystal_present_flag <= CONFIG_RST[`POS_CRYSTAL_PRESENT_FLAG];
            crystal_flag_written <= CONFIG_RST[`POS_CRYSTAL_FLAG_WRITTEN];
            crystal_low_power <= CONFIG_RST[`POS_CRYSTAL_LOW_POWER];
        end else if (write_to(`ADDR_CRYSTAL_CONFIG_LOCK)) begin
            if (!crystal_flag_written) begin
                crystal_present_flag <=
                    wdata[`POS_CRYSTAL_PRESENT_FLAG];
            end
            crystal_flag_written <= 1'b1;
            crystal_low_power <= wdata[`POS_CRYSTAL_LOW_POWER];
        end
    end

    // ****************************************************************
    // Oscillator control zero and watchdog restart
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            crystal_select <= CONTROL_RST[`POS_CRYSTAL_SELECT];
            sleep_interval <= CONTROL_RST[4:3];
        end else if (write_to(`ADDR_OSC_CONTROL_ZERO)) begin
            crystal_select <= wdata[`POS_CRYSTAL_SELECT];
            sleep_interval <= wdata[4:3];
        end
    end

    // The sleep timer lives outside; it sees a one-cycle clear pulse.
    always_ff @(posedge clk) begin
        if (reset) begin
            sleep_timer_clear <= 1'b0;
        end else if (ce) begin
            sleep_timer_clear <= wr && hit(addr, `ADDR_WATCHDOG_RESTART) &&
                (wdata == `WATCHDOG_CLEAR_KEY);
        end
    end

    // ****************************************************************
    // Source switch-over
    // ****************************************************************
    // The timeout pulse is taken regardless of any interrupt enable, and
    // the move back to the internal oscillator never waits for it.
    always_ff @(posedge clk) begin
        if (reset) begin
            clk32_source_crystal <= 1'b0;
        end else if (ce) begin
            if (!crystal_permitted) begin
                clk32_source_crystal <= 1'b0;
            end else if (sleep_timeout) begin
                clk32_source_crystal <= 1'b1;
            end
        end
    end

    // The internal oscillator is stopped on the same edge the crystal takes
    // over, and restarts on the same edge the source falls back.
    always_ff @(posedge clk) begin
        if (reset) begin
            internal_slow_osc_enable <= 1'b1;
        end else if (ce) begin
            if (!crystal_permitted) begin
                internal_slow_osc_enable <= 1'b1;
            end else if (sleep_timeout) begin
                internal_slow_osc_enable <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            crystal_osc_enable <= 1'b0;
        end else if (ce) begin
            crystal_osc_enable <= crystal_permitted;
        end
    end

    crystal_power_mode power_mode (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .run(crystal_osc_enable),
        .selected(clk32_source_crystal),
        .low_power_req(crystal_low_power),
        .state(next_power_state)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            crystal_power_state <= crystal_powerdown_state;
        end else if (ce) begin
            crystal_power_state <= next_power_state;
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Read data stand for exactly the cycle after the strobe; unmapped
    // addresses read as zero, but tune bits 7 and 4 read back as written.
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= 8'h00;
            if (rd) begin
                unique case (addr)
                    `ADDR_LOW_SPEED_OSC_TUNE: begin
                        rdata <= {slow_reserved[1], powerdown_bias_off,
                            slow_freq_select, slow_reserved[0], slow_trim};
                    end
                    `ADDR_CRYSTAL_ENABLE_BUS: begin
                        rdata <= {5'h00, crystal_enable_code};
                    end
                    `ADDR_CRYSTAL_GAIN_POWER_TUNE: begin
                        rdata <= {3'h0, crystal_amp_gain, crystal_gain_mode};
                    end
                    `ADDR_CRYSTAL_CONFIG_LOCK: begin
                        rdata <= {5'h00, crystal_low_power,
                            crystal_flag_written, crystal_present_flag};
                    end
                    `ADDR_OSC_CONTROL_ZERO: begin
                        rdata <= {crystal_select, 2'h0, sleep_interval,
                            3'h0};
                    end
                    `ADDR_CLOCK_STATUS: begin
                        rdata <= {4'h0, crystal_power_state,
                            internal_slow_osc_enable, clk32_source_crystal};
                    end
                    default: begin
                        rdata <= 8'h00;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_tune_write;
        write_to(`ADDR_LOW_SPEED_OSC_TUNE);
    endsequence

    sequence s_timeout_armed;
        ce && crystal_permitted && sleep_timeout;
    endsequence

    property p_freq_select;
        s_tune_write |=> slow_freq_select == $past(wdata[5]);
    endproperty
    a_freq_select: assert property (p_freq_select)
        else $error("frequency select did not follow the write");

    property p_bias_off;
        s_tune_write |=> powerdown_bias_off == $past(wdata[6]);
    endproperty
    a_bias_off: assert property (p_bias_off)
        else $error("power-down mode bit did not follow the write");

    property p_trim_locked;
        (s_tune_write and !boot_pending) |=> $stable(slow_trim);
    endproperty
    a_trim_locked: assert property (p_trim_locked)
        else $error("trim changed by a bus write");

    property p_switch_on_timeout;
        $rose(clk32_source_crystal) |-> $past(sleep_timeout && ce);
    endproperty
    a_switch_on_timeout: assert property (p_switch_on_timeout)
        else $error("crystal selected without a timeout edge");

    property p_switch_back;
        (ce && !crystal_permitted) |=>
            !clk32_source_crystal && internal_slow_osc_enable;
    endproperty
    a_switch_back: assert property (p_switch_back)
        else $error("source not returned to internal oscillator");

    property p_write_once;
        (write_to(`ADDR_CRYSTAL_CONFIG_LOCK) && crystal_flag_written) |=>
            $stable(crystal_present_flag);
    endproperty
    a_write_once: assert property (p_write_once)
        else $error("present flag changed after lock");

    property p_blocked;
        clk32_source_crystal |-> crystal_present_flag;
    endproperty
    a_blocked: assert property (p_blocked)
        else $error("crystal selected while flag clear");

    property p_written;
        write_to(`ADDR_CRYSTAL_CONFIG_LOCK) |=> crystal_flag_written;
    endproperty
    a_written: assert property (p_written)
        else $error("written status not set by config write");

    property p_reset_source;
        @(posedge clk) disable iff (1'b0)
        reset |=> !clk32_source_crystal && internal_slow_osc_enable;
    endproperty
    a_reset_source: assert property (p_reset_source)
        else $error("reset did not select internal oscillator");

    property p_code_gate;
        (ce && crystal_enable_code != `CRYSTAL_CODE_ENABLE) |=>
            !crystal_osc_enable;
    endproperty
    a_code_gate: assert property (p_code_gate)
        else $error("crystal enabled with closed enable code");

    property p_internal_runs;
        internal_slow_osc_enable == !clk32_source_crystal;
    endproperty
    a_internal_runs: assert property (p_internal_runs)
        else $error("internal oscillator state disagrees with source");

    property p_timer_clear;
        (write_to(`ADDR_WATCHDOG_RESTART) && wdata == `WATCHDOG_CLEAR_KEY)
            |=> sleep_timer_clear ##1 !sleep_timer_clear || ce;
    endproperty
    a_timer_clear: assert property (p_timer_clear)
        else $error("clear key did not pulse sleep timer clear");

    property p_latched;
        s_timeout_armed |=> clk32_source_crystal;
    endproperty
    a_latched: assert property (p_latched)
        else $error("armed timeout did not switch source");

endmodule : low_speed_clock_select

// >>> hdl/low_speed_clock_select_consts.svh
`ifndef LOW_SPEED_CLOCK_SELECT_CONSTS_SVH
`define LOW_SPEED_CLOCK_SELECT_CONSTS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_CRYSTAL_ENABLE_BUS 8'hd2
`define ADDR_CRYSTAL_GAIN_POWER_TUNE 8'hd3
`define ADDR_OSC_CONTROL_ZERO 8'he0
`define ADDR_CRYSTAL_CONFIG_LOCK 8'he1
`define ADDR_WATCHDOG_RESTART 8'he3
`define ADDR_CLOCK_STATUS 8'he4
`define ADDR_LOW_SPEED_OSC_TUNE 8'he9

// ****************************************************************
// Reset values
// ****************************************************************
`define RESET_CRYSTAL_ENABLE_BUS 8'h07
`define RESET_CRYSTAL_GAIN_POWER_TUNE 8'h14
`define RESET_CRYSTAL_CONFIG_LOCK 8'h00
`define RESET_LOW_SPEED_OSC_TUNE 8'h18
`define RESET_OSC_CONTROL_ZERO 8'h00

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define POS_POWERDOWN_BIAS_OFF 6
`define POS_SLOW_FREQ_SELECT 5
`define POS_CRYSTAL_PRESENT_FLAG 0
`define POS_CRYSTAL_FLAG_WRITTEN 1
`define POS_CRYSTAL_LOW_POWER 2
`define POS_CRYSTAL_SELECT 7
`define CRYSTAL_CODE_ENABLE 3'h3
`define CRYSTAL_CODE_DISABLE 3'h7
`define WATCHDOG_CLEAR_KEY 8'h38

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS 10
`define XTAL_STEP_DELAY_NS 1000
`define XTAL_STEP_CYCLES \
    ((`XTAL_STEP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> hdl/low_speed_clock_select_pkg.sv
package low_speed_clock_select_pkg;

    typedef enum logic [1:0] {
        crystal_powerdown_state = 2'b00,
        crystal_startup_state = 2'b01,
        crystal_high_power_state = 2'b10,
        crystal_low_power_state = 2'b11
    } crystal_power_t;

    typedef logic [7:0] reg_byte_t;

endpackage : low_speed_clock_select_pkg

// >>> hdl/crystal_power_mode.sv
`timescale 1ns/100ps
`include "low_speed_clock_select_consts.svh"

module crystal_power_mode (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic run,
    input wire logic selected,
    input wire logic low_power_req,
    output low_speed_clock_select_pkg::crystal_power_t state
);
    import low_speed_clock_select_pkg::*;

    localparam logic [6:0] STEP_CYCLES = 7'(`XTAL_STEP_CYCLES);

    logic [6:0] settle;

    // Each mode change except the drop to powerdown is followed by a settle delay before the next one.
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= crystal_powerdown_state;
            settle <= 7'h00;
        end else if (ce) begin
            if (settle != 7'h00) begin
                settle <= settle - 7'h01;
            end
            if (!run) begin
                state <= crystal_powerdown_state;
                settle <= 7'h00;
            end else if (settle == 7'h00) begin
                unique case (state)
                    crystal_powerdown_state: begin
                        state <= crystal_startup_state;
                        settle <= STEP_CYCLES;
                    end
                    crystal_startup_state: begin
                        if (selected) begin
                            state <= crystal_high_power_state;
                            settle <= STEP_CYCLES;
                        end
                    end
                    crystal_high_power_state: begin
                        if (low_power_req) begin
                            state <= crystal_low_power_state;
                            settle <= STEP_CYCLES;
                        end
                    end
                    crystal_low_power_state: begin
                        if (!low_power_req) begin
                            state <= crystal_high_power_state;
                            settle <= STEP_CYCLES;
                        end
                    end
                endcase
            end
        end
    end

    property p_powerdown_when_off;
        @(posedge clk) disable iff (reset)
        (ce && !run) |=> state == crystal_powerdown_state;
    endproperty
    a_powerdown_when_off: assert property (p_powerdown_when_off)
        else $error("crystal not powered down when disabled");

endmodule : crystal_power_mode

// >>> sim/sleep_timer_model.sv
`timescale 1ns/100ps

// ****************************************************************
// Sleep timer beyond the block: its timeout edge times the switch.
// ****************************************************************
module sleep_timer_model #(
    parameter int PERIOD = 50
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    output logic timeout
);
    logic [15:0] count;

    // The interval is shortened so a switch-over fits a short run.
    always_ff @(posedge clk) begin
        if (reset || clear) begin
            count <= 16'h0;
            timeout <= 1'b0;
        end else begin
            count <= (count == 16'(PERIOD - 1)) ? 16'h0 : count + 16'h1;
            timeout <= (count == 16'(PERIOD - 1));
        end
    end
endmodule : sleep_timer_model

// >>> sim/low_speed_clock_select_test.sv
`timescale 1ns/100ps
`include "low_speed_clock_select_consts.svh"

module low_speed_clock_select_test;
    import low_speed_clock_select_pkg::*;
    logic clk = 0, reset = 1, ce = 1, wr = 0, rd = 0, sleep_timeout;
    logic [7:0] addr = 8'h00, wdata = 8'h00, w;
    logic [3:0] factory_trim = 4'ha, slow_trim;
    reg_byte_t rdata;
    logic slow_freq_select, powerdown_bias_off, crystal_low_power;
    logic crystal_osc_enable, internal_slow_osc_enable;
    logic clk32_source_crystal, sleep_timer_clear;
    logic [2:0] crystal_amp_gain;
    logic [1:0] crystal_gain_mode, sleep_interval;
    crystal_power_t crystal_power_state;
    int err_total = 0, n_checks = 0, i, n;

    always #5 clk = ~clk;

    low_speed_clock_select i_dut (.clk, .reset, .ce, .addr, .wdata, .wr,
        .rd, .factory_trim, .sleep_timeout, .rdata, .slow_freq_select,
        .powerdown_bias_off, .slow_trim, .crystal_amp_gain,
        .crystal_gain_mode, .crystal_low_power, .crystal_osc_enable,
        .internal_slow_osc_enable, .clk32_source_crystal,
        .sleep_interval, .sleep_timer_clear, .crystal_power_state);

    sleep_timer_model #(.PERIOD(50)) i_timer (.clk(clk), .reset(reset),
        .clear(sleep_timer_clear), .timeout(sleep_timeout));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] exp_tune(input logic [7:0] v,
                                            input logic [3:0] t);
        return {v[7:4], t};
    endfunction : exp_tune

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task print_verdict;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd_chk

    task do_reset;
        @(posedge clk);
        reset <= 1'b1;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : do_reset

    // Returns just after the edge that shows the timeout pulse.
    task wait_to;
        for (i = 0; i < 200; i++) begin
            @(posedge clk);
            #1;
            if (sleep_timeout === 1'b1)
                break;
        end
        if (i == 200) begin
            err_total++;
            print_verdict();
        end
    endtask : wait_to

    task arm_crystal;
        wr_reg(`ADDR_WATCHDOG_RESTART, `WATCHDOG_CLEAR_KEY);
        wr_reg(`ADDR_OSC_CONTROL_ZERO, 8'h98);
        wait_to();
        chk({7'h0, clk32_source_crystal}, 8'h00);
    endtask : arm_crystal

    initial begin
        w = $urandom(11128);
        do_reset();
        rd_chk(`ADDR_CRYSTAL_ENABLE_BUS, 8'h07);
        rd_chk(`ADDR_CRYSTAL_GAIN_POWER_TUNE, 8'h14);
        rd_chk(`ADDR_CRYSTAL_CONFIG_LOCK, 8'h00);
        rd_chk(`ADDR_LOW_SPEED_OSC_TUNE,
            exp_tune(8'h18, factory_trim));
        chk({4'h0, slow_trim}, {4'h0, factory_trim});
        rd_chk(`ADDR_CLOCK_STATUS, 8'h02);
        rd_chk(8'h55, 8'h00);
        chk({3'h0, crystal_amp_gain, crystal_gain_mode}, 8'h14);
        for (n = 0; n < 6; n++) begin
            w = (n == 0) ? 8'h6f : ($urandom & 8'h6f);
            wr_reg(`ADDR_LOW_SPEED_OSC_TUNE, w);
            rd_chk(`ADDR_LOW_SPEED_OSC_TUNE,
                exp_tune(w, factory_trim));
            chk({6'h0, powerdown_bias_off, slow_freq_select},
                {6'h0, w[6:5]});
            w = $urandom & 8'h1f;
            wr_reg(`ADDR_CRYSTAL_GAIN_POWER_TUNE, w);
            #1 chk({3'h0, crystal_amp_gain, crystal_gain_mode},
                w);
        end
        // A write while the clock enable is low must leave no trace.
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(`ADDR_CRYSTAL_GAIN_POWER_TUNE, ~w & 8'h1f);
        ce <= 1'b1;
        #1 chk({3'h0, crystal_amp_gain, crystal_gain_mode},
            w);
        wr_reg(`ADDR_WATCHDOG_RESTART, 8'h37);
        #1 chk({7'h0, sleep_timer_clear}, 8'h00);
        wr_reg(`ADDR_WATCHDOG_RESTART, `WATCHDOG_CLEAR_KEY);
        #1 chk({7'h0, sleep_timer_clear}, 8'h01);
        // Flag written as zero: the crystal must never be taken.
        wr_reg(`ADDR_CRYSTAL_CONFIG_LOCK, 8'h00);
        wr_reg(`ADDR_CRYSTAL_CONFIG_LOCK, 8'h01);
        rd_chk(`ADDR_CRYSTAL_CONFIG_LOCK, 8'h02);
        wr_reg(`ADDR_CRYSTAL_ENABLE_BUS, 8'h03);
        arm_crystal();
        @(posedge clk);
        #1 chk({6'h0, crystal_osc_enable, clk32_source_crystal},
            8'h00);
        do_reset();
        wr_reg(`ADDR_CRYSTAL_CONFIG_LOCK, 8'h01);
        wr_reg(`ADDR_CRYSTAL_CONFIG_LOCK, 8'h04);
        rd_chk(`ADDR_CRYSTAL_CONFIG_LOCK, 8'h07);
        chk({7'h0, crystal_low_power}, 8'h01);
        wr_reg(`ADDR_CRYSTAL_CONFIG_LOCK, 8'h00);
        rd_chk(`ADDR_CRYSTAL_CONFIG_LOCK, 8'h03);
        wr_reg(`ADDR_CRYSTAL_ENABLE_BUS, 8'h03);
        arm_crystal();
        chk({6'h0, sleep_interval}, 8'h03);
        chk({7'h0, crystal_osc_enable}, 8'h01);
        chk({7'h0, internal_slow_osc_enable}, 8'h01);
        chk({6'h0, crystal_power_state}, 8'h01);
        @(posedge clk);
        #1 chk({6'h0, clk32_source_crystal, internal_slow_osc_enable},
            8'h02);
        // Functions that need an accurate slow clock start only from here.
        rd_chk(`ADDR_CLOCK_STATUS, 8'h05);
        repeat (60) @(posedge clk);
        #1 chk({6'h0, crystal_power_state}, 8'h02);
        wr_reg(`ADDR_OSC_CONTROL_ZERO, 8'h18);
        @(posedge clk);
        #1 chk({6'h0, clk32_source_crystal, internal_slow_osc_enable},
            8'h01);
        arm_crystal();
        @(posedge clk);
        do_reset();
        chk({6'h0, clk32_source_crystal, internal_slow_osc_enable},
            8'h01);
        print_verdict();
    end
endmodule : low_speed_clock_select_test
